/* File: logic/fbsr_defines.vh */
`ifndef FBSR_DEFINES_VH
`define FBSR_DEFINES_VH

`define FBSR_OFS_CONTROL 8'h00
`define FBSR_OFS_STATUS 8'h04
`define FBSR_OFS_INQ 8'h08
`define FBSR_OFS_OUTQ 8'h0c
`define FBSR_OFS_WORK 8'h10
`define FBSR_OFS_COPY 8'h14

`define FBSR_CTL_EN 0
`define FBSR_CTL_DIR 1
`define FBSR_CTL_RESET 2'h0

`define FBSR_ST_LOAD 0
`define FBSR_ST_STORE 1
`define FBSR_ST_RESET 2
`define FBSR_ST_IQ_EMPTY 3
`define FBSR_ST_IQ_PART 4
`define FBSR_ST_OQ_FULL 5
`define FBSR_ST_OQ_PART 6

`define FBSR_OP_SHIFT 3'h4
`define FBSR_OP_CLR_A 3'h5
`define FBSR_OP_LOAD 3'h6
`define FBSR_OP_CLR_B 3'h7

`endif

/* File: logic/fbsr_top.v */
`timescale 1ns/1ps
`include "fbsr_defines.vh"

module fbsr_top #(
    parameter WIDTH = 8,
    parameter IQ_DEPTH = 4,
    parameter OQ_DEPTH = 4
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Application pins
    input wire shift_in,
    input wire load_req,
    input wire store_req,
    input wire reset_req,
    output reg shift_out,
    output reg irq_pulse
);
    localparam IQ_AW = (IQ_DEPTH > 1) ? $clog2(IQ_DEPTH) : 1;
    localparam OQ_AW = (OQ_DEPTH > 1) ? $clog2(OQ_DEPTH) : 1;
    localparam NSLICE = (WIDTH + 7) / 8;

    // Pin synchronisers
    reg [3:0] pin_meta_r;
    reg [3:0] pin_sync_r;
    reg load_prev_r;
    reg store_prev_r;
    wire sin_s = pin_sync_r[0];
    wire load_s = pin_sync_r[1];
    wire store_s = pin_sync_r[2];
    wire reset_s = pin_sync_r[3];

    // Control and state
    reg [1:0] control_r;
    reg [WIDTH-1:0] work_r;
    reg [WIDTH-1:0] work_nxt;
    reg [WIDTH-1:0] copy_r;
    reg [2:0] flags_r;
    reg [2:0] flags_nxt;

    // Queues
    reg [WIDTH-1:0] iq_mem [0:IQ_DEPTH-1];
    reg [IQ_AW-1:0] iq_rd_r;
    reg [IQ_AW-1:0] iq_wr_r;
    reg [IQ_AW:0] iq_cnt_r;
    reg [WIDTH-1:0] oq_mem [0:OQ_DEPTH-1];
    reg [OQ_AW-1:0] oq_rd_r;
    reg [OQ_AW-1:0] oq_wr_r;
    reg [OQ_AW:0] oq_cnt_r;

    // Queue pointer next values
    reg [IQ_AW-1:0] iq_rd_nxt;
    reg [IQ_AW-1:0] iq_wr_nxt;
    reg [IQ_AW:0] iq_cnt_nxt;
    reg [OQ_AW-1:0] oq_rd_nxt;
    reg [OQ_AW-1:0] oq_wr_nxt;
    reg [OQ_AW:0] oq_cnt_nxt;

    // Bus data phase
    reg wr_pend_r;
    reg [7:0] wr_addr_r;

    wire iq_empty = (iq_cnt_r == {(IQ_AW+1){1'b0}});
    wire iq_full = (iq_cnt_r == IQ_DEPTH[IQ_AW:0]);
    wire oq_empty = (oq_cnt_r == {(OQ_AW+1){1'b0}});
    wire oq_full = (oq_cnt_r == OQ_DEPTH[OQ_AW:0]);

    wire enabled = control_r[`FBSR_CTL_EN];
    wire dir_right = control_r[`FBSR_CTL_DIR];
    wire load_edge = load_s & ~load_prev_r;
    wire store_edge = store_s & ~store_prev_r;
    // Enable heads the select; load edge and reset level follow directly
    wire [2:0] op_sel = {enabled, load_edge, reset_s};

    wire addr_ok = hsel & hready & htrans[1];
    wire rd_acc = addr_ok & ~hwrite;
    wire wr_acc = addr_ok & hwrite;
    wire rd_status = rd_acc & (haddr == `FBSR_OFS_STATUS);
    wire rd_outq = rd_acc & (haddr == `FBSR_OFS_OUTQ);
    wire rd_copy = rd_acc & (haddr == `FBSR_OFS_COPY);
    wire wr_inq = wr_pend_r & (wr_addr_r == `FBSR_OFS_INQ);
    wire wr_work = wr_pend_r & (wr_addr_r == `FBSR_OFS_WORK);
    wire wr_ctl = wr_pend_r & (wr_addr_r == `FBSR_OFS_CONTROL);

    // Operation decode
    wire do_shift = (op_sel == `FBSR_OP_SHIFT);
    wire do_load = (op_sel == `FBSR_OP_LOAD) & ~iq_empty;
    wire do_clear = (op_sel == `FBSR_OP_CLR_A) | (op_sel == `FBSR_OP_CLR_B);
    wire do_store = enabled & store_edge & ~oq_full;
    // Hardware store has the single write port first
    wire do_capture = rd_copy & ~oq_full & ~do_store;
    wire oq_push = do_store | do_capture;
    wire oq_pop = rd_outq & ~oq_empty;
    wire iq_push = wr_inq & ~iq_full;

    // Per-bit shift network built one bit at a time across the whole width
    wire [WIDTH-1:0] shifted;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // End bits take sin_s in place of the missing neighbour
            wire from_low = (i == 0) ? sin_s : work_r[(i == 0) ? 0 : i-1];
            wire from_high = (i == WIDTH-1) ? sin_s : work_r[(i == WIDTH-1) ? i : i+1];
            assign shifted[i] = dir_right ? from_high : from_low;
        end
    endgenerate

    always @* begin
        work_nxt = work_r;
        if (wr_work) begin
            work_nxt = hwdata[WIDTH-1:0];
        end else if (do_clear) begin
            work_nxt = {WIDTH{1'b0}};
        end else if (do_load) begin
            work_nxt = iq_mem[iq_rd_r];
        end else if (do_shift) begin
            work_nxt = shifted;
        end
    end

    always @* begin
        flags_nxt = rd_status ? 3'h0 : flags_r;
        if (do_load) begin
            flags_nxt[`FBSR_ST_LOAD] = 1'b1;
        end
        if (do_store) begin
            flags_nxt[`FBSR_ST_STORE] = 1'b1;
        end
        if (do_clear) begin
            flags_nxt[`FBSR_ST_RESET] = 1'b1;
        end
    end

    wire iq_partial = ~iq_empty & ~iq_full;
    wire oq_partial = ~oq_empty & ~oq_full;
    wire [7:0] status_word = {
        1'b0,
        oq_partial,
        oq_full,
        iq_partial,
        iq_empty,
        flags_r};

    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h0000_0000;
        case (haddr)
            `FBSR_OFS_CONTROL: rd_word[1:0] = control_r;
            `FBSR_OFS_STATUS: rd_word[7:0] = status_word;
            `FBSR_OFS_OUTQ: rd_word[WIDTH-1:0] = oq_empty ? {WIDTH{1'b0}} : oq_mem[oq_rd_r];
            `FBSR_OFS_WORK: rd_word[WIDTH-1:0] = work_r;
            `FBSR_OFS_COPY: rd_word[WIDTH-1:0] = copy_r;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Pin synchronisers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_meta_r <= {reset_req, store_req, load_req, shift_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    // Edge history for load and store
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_prev_r <= 1'b0;
            store_prev_r <= 1'b0;
        end else begin
            load_prev_r <= load_s;
            store_prev_r <= store_s;
        end
    end

    // No wait states
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Response is always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Read data captured at the address edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            hrdata <= rd_word;
        end
    end

    // Write pending for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
        end else begin
            wr_pend_r <= wr_acc;
        end
    end

    // Address held for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_r <= 8'h00;
        end else if (addr_ok) begin
            wr_addr_r <= haddr;
        end
    end

    // Control register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_r <= `FBSR_CTL_RESET;
        end else if (wr_ctl) begin
            control_r <= hwdata[1:0];
        end
    end

    // Working register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            work_r <= {WIDTH{1'b0}};
        end else begin
            work_r <= work_nxt;
        end
    end

    // Copy trails the working register by one cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            copy_r <= {WIDTH{1'b0}};
        end else begin
            copy_r <= work_r;
        end
    end

    // Bit that leaves on the next shift
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_out <= 1'b0;
        end else begin
            shift_out <= dir_right ? work_nxt[0] : work_nxt[WIDTH-1];
        end
    end

    // Event flags
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= 3'h0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Pulse when any flag rises
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_pulse <= 1'b0;
        end else begin
            irq_pulse <= |(flags_nxt & ~flags_r);
        end
    end

    // Input queue pointers
    always @* begin
        iq_rd_nxt = iq_rd_r;
        iq_wr_nxt = iq_wr_r;
        iq_cnt_nxt = iq_cnt_r;
        if (iq_push) begin
            iq_wr_nxt = (iq_wr_r == IQ_DEPTH-1) ? {IQ_AW{1'b0}} : iq_wr_r + 1'b1;
        end
        if (do_load) begin
            iq_rd_nxt = (iq_rd_r == IQ_DEPTH-1) ? {IQ_AW{1'b0}} : iq_rd_r + 1'b1;
        end
        if (iq_push & ~do_load) begin
            iq_cnt_nxt = iq_cnt_r + 1'b1;
        end else if (do_load & ~iq_push) begin
            iq_cnt_nxt = iq_cnt_r - 1'b1;
        end
    end

    // Output queue pointers
    always @* begin
        oq_rd_nxt = oq_rd_r;
        oq_wr_nxt = oq_wr_r;
        oq_cnt_nxt = oq_cnt_r;
        if (oq_push) begin
            oq_wr_nxt = (oq_wr_r == OQ_DEPTH-1) ? {OQ_AW{1'b0}} : oq_wr_r + 1'b1;
        end
        if (oq_pop) begin
            oq_rd_nxt = (oq_rd_r == OQ_DEPTH-1) ? {OQ_AW{1'b0}} : oq_rd_r + 1'b1;
        end
        if (oq_push & ~oq_pop) begin
            oq_cnt_nxt = oq_cnt_r + 1'b1;
        end else if (oq_pop & ~oq_push) begin
            oq_cnt_nxt = oq_cnt_r - 1'b1;
        end
    end

    // Input queue pointer registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iq_rd_r <= {IQ_AW{1'b0}};
            iq_wr_r <= {IQ_AW{1'b0}};
            iq_cnt_r <= {(IQ_AW+1){1'b0}};
        end else begin
            iq_rd_r <= iq_rd_nxt;
            iq_wr_r <= iq_wr_nxt;
            iq_cnt_r <= iq_cnt_nxt;
        end
    end

    // Output queue pointer registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oq_rd_r <= {OQ_AW{1'b0}};
            oq_wr_r <= {OQ_AW{1'b0}};
            oq_cnt_r <= {(OQ_AW+1){1'b0}};
        end else begin
            oq_rd_r <= oq_rd_nxt;
            oq_wr_r <= oq_wr_nxt;
            oq_cnt_r <= oq_cnt_nxt;
        end
    end

    // Queue storage needs no reset
    always @(posedge hclk) begin
        if (iq_push) begin
            iq_mem[iq_wr_r] <= hwdata[WIDTH-1:0];
        end
    end

    always @(posedge hclk) begin
        if (oq_push) begin
            oq_mem[oq_wr_r] <= do_store ? work_r : copy_r;
        end
    end
endmodule

/* File: bench/fbsr_checker.sv */
`timescale 1ns/1ps
module fbsr_checker #(parameter WIDTH = 8) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire load_req,
    input wire store_req,
    input wire reset_req,
    input wire irq_pulse
);
    logic [3:0] quiet_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles since an event pin was high
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            quiet_r <= 4'h0;
        else if (load_req | store_req | reset_req)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end
    sequence rd(logic [7:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr == a;
    endsequence
    a_width_bound: assert property (rd(8'h10) |=> (hrdata >> WIDTH) == 32'h0)
        else $error("working register too wide");
    a_ctl_bits: assert property (rd(8'h00) |=> hrdata[31:2] == 30'h0)
        else $error("control high bits set");
    a_status_top: assert property (rd(8'h04) |=> hrdata[31:7] == 25'h0)
        else $error("status high bits set");
    a_inq_excl: assert property (rd(8'h04) |=> !(hrdata[3] && hrdata[4]))
        else $error("input queue empty and partial");
    a_outq_excl: assert property (rd(8'h04) |=> !(hrdata[5] && hrdata[6]))
        else $error("output queue full and partial");
    a_irq_cause: assert property (irq_pulse |-> quiet_r < 4'h8)
        else $error("interrupt without event");
    a_flags_clear: assert property (rd(8'h04) ##2 (rd(8'h04) ##0 quiet_r > 4'h8)
        |=> hrdata[2:0] == 3'h0) else $error("event flags not cleared");
    a_unmapped_zero: assert property ((hsel && hready && htrans[1] && !hwrite
        && haddr > 8'h14) |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind fbsr_top fbsr_checker #(.WIDTH(WIDTH)) fbsr_checker_i (.*);

/* File: bench/fbsr_app_model.sv */
`timescale 1ns/1ps
module fbsr_app_model (
    input wire hclk,
    input wire [3:0] want,
    output logic shift_in,
    output logic load_req,
    output logic store_req,
    output logic reset_req
);
    initial {reset_req, store_req, load_req, shift_in} = 4'h0;
    // Pin levels copied from want one clock later
    always @(posedge hclk) begin
        {reset_req, store_req, load_req, shift_in} <= want;
    end
endmodule

/* File: bench/fbsr_tb_top.sv */
`timescale 1ns/1ps
module fbsr_tb_top;
    localparam W = 16;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, q, v, u;
    logic [3:0] want = 4'h0;
    wire [31:0] hrdata;
    wire hreadyout, shift_in, load_req, store_req, reset_req, so, resp;
    int num_errors = 0;
    int total_checks = 0;
    always #5 hclk = ~hclk;
    fbsr_top #(.WIDTH(W)) fbsr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(resp),
        .shift_in(shift_in), .load_req(load_req), .store_req(store_req),
        .reset_req(reset_req), .shift_out(so), .irq_pulse());
    fbsr_app_model fbsr_app_model_i (.hclk(hclk), .want(want), .shift_in(shift_in),
        .load_req(load_req), .store_req(store_req), .reset_req(reset_req));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e);
        total_checks++;
        if (q !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, q);
        end
    endtask
    task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e);
    endtask
    task automatic pins(input logic [3:0] w);
        want <= w;
        repeat (2) @(posedge hclk);
        want <= {3'h0, w[0]};
        repeat (10) @(posedge hclk);
    endtask
    function automatic logic shifted(input logic [31:0] x, input logic [31:0] s);
        for (int k = 1; k < W; k++) begin
            if (x == ((s << k) & 32'hffff))
                return 1'b1;
        end
        return 1'b0;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(6930));
        v = ($urandom & 32'hffff) | 32'h1;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h00, "control", 32'h0);
        rd(8'h04, "status", 32'h8);
        rd(8'h18, "unmapped", 32'h0);
        for (int d = 0; d < 2; d++) begin
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b1, 8'h10, 32'h0);
            pins(4'h1);
            bus(1'b1, 8'h00, {30'h0, d == 1, 1'b1});
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b0, 8'h10, 32'h0);
            q = {31'h0, d == 1 ? shifted(q, 32'hffff) : shifted(~q & 32'hffff, 32'hffff)};
            chk("direction fill", 32'h1);
        end
        bus(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge hclk);
        repeat (5) pins(4'h5);
        rd(8'h04, "full status", 32'h2a);
        for (int i = 0; i < 5; i++)
            rd(8'h0c, "output queue", i < 4 ? 32'hffff : 32'h0);
        bus(1'b1, 8'h08, v);
        want <= 4'hb;
        repeat (8) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h0);
        want <= 4'h0;
        rd(8'h10, "cleared", 32'h0);
        rd(8'h04, "reset status", 32'h14);
        bus(1'b1, 8'h00, 32'h1);
        pins(4'h2);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        u = q;
        q = {31'h0, shifted(u, v)};
        chk("load shift", 32'h1);
        q = {30'h0, resp, so};
        chk("shift out and response", {30'h0, 1'b0, u[W-1]});
        v = u;
        rd(8'h14, "copy", v);
        rd(8'h0c, "captured", v);
        rd(8'h04, "load status", 32'h9);
        rd(8'h04, "status reread", 32'h8);
        tally_and_finish;
    end
endmodule
